// File: verilog/saf_pkg.sv
// shared constants, state codes and helpers of the result formatter
// assumes one 25 MHz clock domain and eight converter channels
package saf_pkg;

	// ==========================================================
	// sizes
	localparam int CH_NUM     = 8;   // simultaneous channels
	localparam int CODE_W     = 20;  // converter resolution
	localparam int WORD_W     = 24;  // output word, room for averaging
	localparam int RANGE_W    = 4;   // input range code width
	localparam int GAIN_W     = 16;  // gain correction width
	localparam int CHAN_W     = 3;   // channel tag width
	localparam int LANE_MAX   = 8;   // result data lines in cmos mode
	localparam int FIFO_DEPTH = 8;   // words buffered before the lines
	localparam int ACC_W      = 25;  // averaging accumulator
	localparam int SAT_W      = 40;  // correction arithmetic width
	localparam int OS_CNT_W   = 4;   // averaged-sample counter

	// ==========================================================
	// reset values and fixed figures
	localparam logic [RANGE_W-1:0] RANGE_RESET = 4'hF;    // +-40 V
	localparam logic [GAIN_W-1:0]  GAIN_UNITY  = 16'h8000; // 1.00000
	localparam int                 GAIN_FRAC   = 15;
	localparam int                 HIGAIN_SHIFT = 2;      // x4 path
	localparam logic [4:0]         BIT_TOP     = 5'h13;   // msb index
	localparam logic [CODE_W-1:0]  SAR_INIT    = 20'h80000;
	localparam logic [1:0]         OS_TOP      = 2'h3;
	localparam logic signed [SAT_W-1:0] CODE_MID = 40'sh0000080000;
	localparam logic signed [SAT_W-1:0] BIP_MAX  = 40'sh000007FFFF;
	localparam logic signed [SAT_W-1:0] BIP_MIN  = -40'sh0000080000;
	localparam logic signed [SAT_W-1:0] UNI_MAX  = 40'sh00000FFFFF;
	localparam logic [CODE_W-1:0]  CODE_POS    = 20'h7FFFF;
	localparam logic [CODE_W-1:0]  CODE_NEG    = 20'h80000;
	localparam logic [CODE_W-1:0]  CODE_FULL   = 20'hFFFFF;

	// ==========================================================
	// states
	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_GAIN   = 3'b001,
		S_SAR    = 3'b010,
		S_FORMAT = 3'b011,
		S_PUSH   = 3'b100
	} saf_state_e;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_NAP    = 2'b01,
		PWR_DOWN   = 2'b10
	} saf_power_e;

	// ==========================================================
	// helpers
	// span index 0 is the widest (40 V) range, 7 the narrowest
	function automatic logic [2:0] saf_span(
		input logic [RANGE_W-1:0] code);
		return ~code[3:1];
	endfunction

	// enable mask for the lowest n result lines
	function automatic logic [LANE_MAX-1:0] saf_lane_mask(
		input logic [3:0] n);
		return 8'((16'h0001 << n) - 16'h0001);
	endfunction

endpackage

// File: verilog/saf_result_fifo.sv
// small synchronous fifo between result formatting and the lines
// assumes one clock; reads and writes may happen in the same cycle
`timescale 1ns/1ps

module saf_result_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // word storage
	logic [AW:0]      wrPtr_q;       // extra bit tells full from empty
	logic [AW:0]      rdPtr_q;
	logic             doWrite;
	logic             doRead;

	// ==========================================================
	// flags
	assign inReady  = !((wrPtr_q[AW] != rdPtr_q[AW]) &&
		(wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
	assign outValid = (wrPtr_q != rdPtr_q);
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;
	assign outData  = mem[rdPtr_q[AW-1:0]];

	// storage has no reset, only pointers decide what is valid
	always_ff @(posedge ref_clk) begin
		if (doWrite) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	// pointers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doRead) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

endmodule

// File: verilog/saf_adc_formatter.sv
// conversion control and result formatting of the 8-channel converter
// assumes synchronous pins, configuration writes from the separate
// serial configuration slave and a comparator per channel
`timescale 1ns/1ps

// Overview of operation
// - start rising edge holds all channels, converts
// - successive approximation, twenty bits per channel
// - results queued only after all channels finish
// - bipolar twos complement, unipolar straight binary
// - odd codes pick bipolar spans, widest first
// - even codes pick unipolar spans, widest first
// - each channel keeps its own range
// - auto gain chooses path gain per sample
// - pin selects lvds or cmos result bus
// - cmos mode uses one to eight lines
// - configuration arrives on its own port
// - optional averaging gives 24-bit results
// - per-channel offset and gain correction
// - nap and power-down while not converting
// - ranges reset to code fifteen, writable
// - auto gain on after reset, per-channel clear
module saf_adc_formatter import saf_pkg::*; #(
	parameter int NUM_CH = CH_NUM,
	parameter int DEPTH  = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// conversion control and comparators
	input  wire logic                     conversionStart,
	input  wire logic [NUM_CH-1:0]        compKeep,
	input  wire logic [NUM_CH-1:0]        smallSignal,
	// configuration writes
	input  wire logic                     rangeWrEn,
	input  wire logic [CHAN_W-1:0]        rangeWrChan,
	input  wire logic [RANGE_W-1:0]       rangeWrCode,
	input  wire logic                     agrWrEn,
	input  wire logic [NUM_CH-1:0]        agrWrMask,
	input  wire logic                     offsetWrEn,
	input  wire logic [CHAN_W-1:0]        offsetWrChan,
	input  wire logic [CODE_W-1:0]        offsetWrValue,
	input  wire logic                     gainWrEn,
	input  wire logic [CHAN_W-1:0]        gainWrChan,
	input  wire logic [GAIN_W-1:0]        gainWrValue,
	input  wire logic                     osEnable,
	input  wire logic [1:0]               osRatio,
	input  wire logic                     napReq,
	input  wire logic                     powerDownReq,
	// output bus straps
	input  wire logic                     lvdsSelect,
	input  wire logic [2:0]               cmosLanes,
	// analog front end drive
	output logic                          trackHold_q,
	output logic [NUM_CH*CODE_W-1:0]      approxArray_q,
	output logic [NUM_CH-1:0]             gainSel_q,
	output logic [NUM_CH*3-1:0]           spanIdx_q,
	// status
	output logic                          busy_q,
	output saf_power_e                    powerState_q,
	output logic [NUM_CH*RANGE_W-1:0]     rangeCodes_q,
	output logic [NUM_CH-1:0]             agrEn_q,
	// result lines
	output logic [LANE_MAX-1:0]           resultLines_q,
	output logic [LANE_MAX-1:0]           resultLinesOe_q,
	output logic                          lvdsData_q,
	output logic                          lvdsOe_q,
	output logic                          wordStart_q,
	output logic [CHAN_W-1:0]             resultChan_q
);
	localparam int FW = CHAN_W + WORD_W;

	// ==========================================================
	// declarations
	saf_state_e                 state_q;        // sequencer
	logic                       startPrev_q;    // for edge detect
	logic                       accept;         // start taken
	logic [RANGE_W-1:0]         range_q [NUM_CH];
	logic signed [CODE_W-1:0]   offset_q [NUM_CH];
	logic [GAIN_W-1:0]          gain_q [NUM_CH];
	logic [NUM_CH-1:0]          bipolar_q;      // latched per sample
	logic [CODE_W-1:0]          approx_q [NUM_CH];
	logic [4:0]                 bitIdx_q;       // current trial bit
	logic [CHAN_W-1:0]          pushIdx_q;
	logic [OS_CNT_W-1:0]        osCnt_q;        // samples in window
	logic [OS_CNT_W-1:0]        osLast;
	logic signed [ACC_W-1:0]    acc_q [NUM_CH];
	logic [WORD_W-1:0]          word_q [NUM_CH];
	logic                       fifoInValid;
	logic                       fifoInReady;
	logic [FW-1:0]              fifoInData;
	logic                       fifoOutValid;
	logic                       fifoOutReady;
	logic [FW-1:0]              fifoOutData;
	logic                       serBusy_q;
	logic [WORD_W-1:0]          shift_q;
	logic [5:0]                 bitsLeft_q;
	logic [3:0]                 laneCnt_q;
	logic                       lvdsMode_q;

	// ==========================================================
	// helper functions
	// one successive approximation step on a trial code
	function automatic logic [CODE_W-1:0] sarStep(
		input logic [CODE_W-1:0] a,
		input logic [4:0]        idx,
		input logic              keep);
		logic [CODE_W-1:0] n;
		n = a;
		if (!keep) begin
			n[idx] = 1'b0;
		end
		if (idx != 5'h00) begin
			n[idx - 5'h01] = 1'b1;
		end
		return n;
	endfunction

	// raw code to corrected, saturated output code
	function automatic logic [CODE_W-1:0] fmtCode(
		input logic [CODE_W-1:0]        raw,
		input logic                     bip,
		input logic                     hi,
		input logic signed [CODE_W-1:0] off,
		input logic [GAIN_W-1:0]        gain);
		logic signed [SAT_W-1:0] v;
		logic signed [SAT_W-1:0] s;
		v = $signed({20'h00000, raw});
		if (bip) begin
			v = v - CODE_MID;
		end
		// high-gain samples are scaled back into the range format
		if (hi) begin
			v = v >>> HIGAIN_SHIFT;
		end
		s = v * $signed({24'h000000, gain});
		s = (s >>> GAIN_FRAC) + $signed({{20{off[CODE_W-1]}}, off});
		if (bip) begin
			if (s > BIP_MAX) begin
				return CODE_POS;
			end else if (s < BIP_MIN) begin
				return CODE_NEG;
			end
		end else begin
			if (s < 0) begin
				return '0;
			end else if (s > UNI_MAX) begin
				return CODE_FULL;
			end
		end
		return s[CODE_W-1:0];
	endfunction

	// widen a code by its coding
	function automatic logic signed [ACC_W-1:0] extCode(
		input logic [CODE_W-1:0] c,
		input logic              bip);
		if (bip) begin
			return $signed({{5{c[CODE_W-1]}}, c});
		end
		return $signed({5'h00, c});
	endfunction

	// ==========================================================
	// start edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			startPrev_q <= 1'b0;
		end else begin
			startPrev_q <= conversionStart;
		end
	end

	// a start during conversion or low power is ignored
	assign accept = conversionStart && !startPrev_q &&
		(state_q == S_IDLE) && (powerState_q == PWR_ACTIVE);

	// ==========================================================
	// configuration registers, written from the config port only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < NUM_CH; c++) begin
				range_q[c]  <= RANGE_RESET;
				offset_q[c] <= '0;
				gain_q[c]   <= GAIN_UNITY;
			end
			agrEn_q <= '1;
		end else begin
			// range, offset and gain writes touch one channel alone; the auto gain write sets the whole mask
			if (rangeWrEn) begin
				range_q[rangeWrChan] <= rangeWrCode;
			end
			if (agrWrEn) begin
				agrEn_q <= agrWrMask;
			end
			if (offsetWrEn) begin
				offset_q[offsetWrChan] <= offsetWrValue;
			end
			if (gainWrEn) begin
				gain_q[gainWrChan] <= gainWrValue;
			end
		end
	end

	// readback packing
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			rangeCodes_q[c*RANGE_W +: RANGE_W] = range_q[c];
			approxArray_q[c*CODE_W +: CODE_W]  = approx_q[c];
		end
	end

	// ==========================================================
	// sequencer
	assign osLast = OS_CNT_W'((5'h02 << osRatio) - 5'h01);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= S_IDLE;
			bitIdx_q  <= '0;
			pushIdx_q <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						state_q <= S_GAIN;
					end
				end
				S_GAIN: begin
					state_q  <= S_SAR;
					bitIdx_q <= BIT_TOP;
				end
				S_SAR: begin
					if (bitIdx_q == 5'h00) begin
						state_q <= S_FORMAT;
					end else begin
						bitIdx_q <= bitIdx_q - 5'h01;
					end
				end
				S_FORMAT: begin
					// mid-window samples wait for the next start
					if (osEnable && (osCnt_q != osLast)) begin
						state_q <= S_IDLE;
					end else begin
						state_q   <= S_PUSH;
						pushIdx_q <= '0;
					end
				end
				S_PUSH: begin
					// stalls while the fifo is full
					if (fifoInReady) begin
						if (pushIdx_q == CHAN_W'(NUM_CH - 1)) begin
							state_q <= S_IDLE;
						end else begin
							pushIdx_q <= pushIdx_q + 1'b1;
						end
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// track/hold and busy flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trackHold_q <= 1'b0;
			busy_q      <= 1'b0;
		end else begin
			if (accept) begin
				trackHold_q <= 1'b1;
				busy_q      <= 1'b1;
			end else if (state_q == S_SAR && bitIdx_q == 5'h00) begin
				trackHold_q <= 1'b0;
			end
			if (state_q == S_PUSH && fifoInReady &&
				pushIdx_q == CHAN_W'(NUM_CH - 1)) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// per-channel sampling setup and approximation
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bipolar_q <= '0;
			gainSel_q <= '0;
			spanIdx_q <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				approx_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (accept) begin
					// snapshot so a range write mid-conversion is harmless
					bipolar_q[c] <= range_q[c][0];
					spanIdx_q[c*3 +: 3] <= saf_span(range_q[c]);
				end
				if (state_q == S_GAIN) begin
					gainSel_q[c] <= agrEn_q[c] && smallSignal[c];
					approx_q[c]  <= SAR_INIT;
				end else if (state_q == S_SAR) begin
					approx_q[c] <= sarStep(approx_q[c], bitIdx_q,
						compKeep[c]);
				end
			end
		end
	end

	// ==========================================================
	// formatting and averaging
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			osCnt_q <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				acc_q[c]  <= '0;
				word_q[c] <= '0;
			end
		end else if (!osEnable) begin
			// leaving averaging restarts the next window cleanly
			osCnt_q <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				acc_q[c] <= '0;
				if (state_q == S_FORMAT) begin
					word_q[c] <= WORD_W'(extCode(fmtCode(approx_q[c],
						bipolar_q[c], gainSel_q[c], offset_q[c],
						gain_q[c]), bipolar_q[c]));
				end
			end
		end else if (state_q == S_FORMAT) begin
			osCnt_q <= (osCnt_q == osLast) ? '0 : osCnt_q + 1'b1;
			for (int c = 0; c < NUM_CH; c++) begin
				if (osCnt_q == osLast) begin
					acc_q[c]  <= '0;
					word_q[c] <= WORD_W'((acc_q[c] + extCode(fmtCode(
						approx_q[c], bipolar_q[c], gainSel_q[c],
						offset_q[c], gain_q[c]), bipolar_q[c]))
						<<< (OS_TOP - osRatio));
				end else begin
					acc_q[c] <= acc_q[c] + extCode(fmtCode(approx_q[c],
						bipolar_q[c], gainSel_q[c], offset_q[c],
						gain_q[c]), bipolar_q[c]);
				end
			end
		end
	end

	// ==========================================================
	// result buffer
	assign fifoInValid  = (state_q == S_PUSH);
	assign fifoInData   = {pushIdx_q, word_q[pushIdx_q]};
	assign fifoOutReady = !serBusy_q;

	saf_result_fifo #(
		.WIDTH (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// ==========================================================
	// serializer onto the result lines, msb first
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			serBusy_q       <= 1'b0;
			shift_q         <= '0;
			bitsLeft_q      <= '0;
			laneCnt_q       <= 4'h1;
			lvdsMode_q      <= 1'b0;
			resultLines_q   <= '0;
			resultLinesOe_q <= '0;
			lvdsData_q      <= 1'b0;
			lvdsOe_q        <= 1'b0;
			wordStart_q     <= 1'b0;
			resultChan_q    <= '0;
		end else if (!serBusy_q) begin
			resultLines_q <= '0;
			lvdsData_q    <= 1'b0;
			wordStart_q   <= 1'b0;
			// strap decides the bus between words
			lvdsOe_q        <= lvdsSelect;
			resultLinesOe_q <= lvdsSelect ? '0 :
				saf_lane_mask({1'b0, cmosLanes} + 4'h1);
			if (fifoOutValid) begin
				serBusy_q    <= 1'b1;
				shift_q      <= fifoOutData[WORD_W-1:0];
				resultChan_q <= fifoOutData[FW-1:WORD_W];
				bitsLeft_q   <= 6'(WORD_W);
				lvdsMode_q   <= lvdsSelect;
				laneCnt_q    <= lvdsSelect ? 4'h1 :
					{1'b0, cmosLanes} + 4'h1;
			end
		end else begin
			wordStart_q <= (bitsLeft_q == 6'(WORD_W));
			for (int j = 0; j < LANE_MAX; j++) begin
				resultLines_q[j] <= !lvdsMode_q &&
					(4'(j) < laneCnt_q) && shift_q[WORD_W-1-j];
			end
			lvdsData_q <= lvdsMode_q && shift_q[WORD_W-1];
			shift_q    <= shift_q << laneCnt_q;
			if (bitsLeft_q <= {2'b00, laneCnt_q}) begin
				serBusy_q <= 1'b0;
			end else begin
				bitsLeft_q <= bitsLeft_q - {2'b00, laneCnt_q};
			end
		end
	end

	// ==========================================================
	// power states, changed only between conversions
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			powerState_q <= PWR_ACTIVE;
		end else if (state_q == S_IDLE && !busy_q) begin
			if (powerDownReq) begin
				powerState_q <= PWR_DOWN;
			end else if (napReq) begin
				powerState_q <= PWR_NAP;
			end else begin
				powerState_q <= PWR_ACTIVE;
			end
		end
	end

	// ==========================================================
	// checks
	a_hold_on_start: assert property (@(posedge ref_clk)
		disable iff (!rst_n) accept |=> trackHold_q && busy_q)
		else $error("start edge did not enter hold");

	a_sar_length: assert property (@(posedge ref_clk)
		disable iff (!rst_n) $rose(trackHold_q) |->
		##21 state_q == S_FORMAT)
		else $error("approximation did not take twenty steps");

	a_push_after_all: assert property (@(posedge ref_clk)
		disable iff (!rst_n) $rose(fifoInValid) |->
		$past(state_q) == S_FORMAT && !trackHold_q)
		else $error("results queued before conversion ended");

	a_bipolar_msb: assert property (@(posedge ref_clk)
		disable iff (!rst_n) (state_q == S_FORMAT && !osEnable &&
		bipolar_q[0] && !gainSel_q[0] && offset_q[0] == '0 &&
		gain_q[0] == GAIN_UNITY) |=>
		word_q[0][CODE_W-1] == !$past(approx_q[0][CODE_W-1]))
		else $error("bipolar code not twos complement");

	a_unipolar_word: assert property (@(posedge ref_clk)
		disable iff (!rst_n) (state_q == S_FORMAT && !osEnable &&
		!bipolar_q[0]) |=> word_q[0][WORD_W-1:CODE_W] == '0)
		else $error("unipolar code not straight binary");

	a_span_snap: assert property (@(posedge ref_clk)
		disable iff (!rst_n) accept |=> spanIdx_q[2:0] ==
		~$past(range_q[0][3:1]) && bipolar_q[0] ==
		$past(range_q[0][0]))
		else $error("span or coding not taken from range code");

	a_range_alone: assert property (@(posedge ref_clk)
		disable iff (!rst_n) (rangeWrEn && rangeWrChan != '0) |=>
		$stable(rangeCodes_q[RANGE_W-1:0]))
		else $error("range write disturbed another channel");

	a_gain_pick: assert property (@(posedge ref_clk)
		disable iff (!rst_n) state_q == S_GAIN |=>
		gainSel_q == $past(agrEn_q & smallSignal))
		else $error("gain choice ignores auto gain setting");

	a_lvds_lines: assert property (@(posedge ref_clk)
		disable iff (!rst_n) lvdsOe_q |->
		resultLinesOe_q == '0 && resultLines_q == '0)
		else $error("cmos lines driven in lvds mode");

	a_cmos_lanes: assert property (@(posedge ref_clk)
		disable iff (!rst_n) (serBusy_q && !lvdsMode_q) |=>
		(resultLines_q & ~saf_lane_mask($past(laneCnt_q))) == '0)
		else $error("data beyond the selected lines");

	a_os_window: assert property (@(posedge ref_clk)
		disable iff (!rst_n) (state_q == S_FORMAT && osEnable &&
		osCnt_q != osLast) |=> busy_q && state_q == S_IDLE)
		else $error("busy fell inside averaging window");

	a_power_idle: assert property (@(posedge ref_clk)
		disable iff (!rst_n) powerState_q != PWR_ACTIVE |->
		!accept && !trackHold_q)
		else $error("conversion while in low power");

endmodule

// File: bench/saf_host_rx.sv
// host side receiver: collects result words from the result lines
// assumes words start on wordStart and arrive msb first, line 0 first
`timescale 1ns/1ps

module saf_host_rx (
	// clock
	input  wire logic        ref_clk,
	// lines from the device
	input  wire logic [7:0]  lines,
	input  wire logic        lvdsBit,
	input  wire logic        wordStart,
	input  wire logic [2:0]  chan,
	// straps as the host wires them
	input  wire logic        lvds,
	input  wire logic [2:0]  lanes,
	// collected words
	output logic [7:0][23:0] words,
	output int               nWords = 0
);
	logic [31:0] acc;     // shift register of received bits
	logic [2:0]  ch;      // channel of the word in flight
	int          cnt = 0; // groups taken so far
	int          lw;      // lines in use
	int          k;       // groups per word

	// ==========================================================
	// receiver
	// padding bits at the tail are shifted out again at the end
	always @(posedge ref_clk) begin
		lw = lvds ? 1 : lanes + 1;
		k = (24 + lw - 1) / lw;
		if (wordStart) begin
			cnt = 0;
			acc = 0;
			ch = chan;
		end
		if (wordStart || cnt > 0) begin
			for (int j = 0; j < lw; j++)
				acc = {acc[30:0], lvds ? lvdsBit : lines[j]};
			cnt++;
			if (cnt == k) begin
				words[ch] <= 24'(acc >> (k * lw - 24));
				nWords <= nWords + 1;
				cnt = 0;
			end
		end
	end
endmodule

// File: bench/tb.sv
// self-checking bench of the converter control and formatter
// assumes a comparator model that keeps a trial bit at or below target
`timescale 1ns/1ps

module tb import saf_pkg::*;;
	// ch0..ch7 range codes, one nibble each
	localparam logic [31:0] CODEW = 32'h87012DEF;
	logic ref_clk = 0, rst_n = 0, conversionStart = 0, rangeWrEn = 0;
	logic agrWrEn = 0, offsetWrEn = 0, gainWrEn = 0, osEnable = 0;
	logic napReq = 0, powerDownReq = 0, lvdsSelect = 0;
	logic [7:0] compKeep, smallSignal = 0, agrWrMask = 0;
	logic [2:0] rangeWrChan = 0, offsetWrChan = 0, gainWrChan = 0;
	logic [2:0] cmosLanes = 0, resultChan_q;
	logic [3:0] rangeWrCode = 0;
	logic [19:0] offsetWrValue = 0, tgt[8], off[8];
	logic [15:0] gainWrValue = 0, gn[8];
	logic [1:0] osRatio = 0;
	logic trackHold_q, busy_q, lvdsData_q, lvdsOe_q, wordStart_q;
	logic [159:0] approxArray_q;
	logic [7:0] gainSel_q, agrEn_q, resultLines_q, resultLinesOe_q;
	logic [23:0] spanIdx_q;
	logic [31:0] rangeCodes_q;
	saf_power_e powerState_q;
	logic [7:0][23:0] words;
	int nWords, n_fail = 0, num_checks = 0, early = 0, c, m;

	saf_adc_formatter uut (.ref_clk, .rst_n, .conversionStart,
		.compKeep, .smallSignal, .rangeWrEn, .rangeWrChan, .rangeWrCode,
		.agrWrEn, .agrWrMask, .offsetWrEn, .offsetWrChan, .offsetWrValue,
		.gainWrEn, .gainWrChan, .gainWrValue, .osEnable, .osRatio, .napReq,
		.powerDownReq, .lvdsSelect, .cmosLanes, .trackHold_q,
		.approxArray_q, .gainSel_q, .spanIdx_q, .busy_q, .powerState_q,
		.rangeCodes_q, .agrEn_q, .resultLines_q, .resultLinesOe_q,
		.lvdsData_q, .lvdsOe_q, .wordStart_q, .resultChan_q);
	saf_host_rx rx (.ref_clk, .lines(resultLines_q), .lvdsBit(lvdsData_q),
		.wordStart(wordStart_q), .chan(resultChan_q), .lvds(lvdsSelect),
		.lanes(cmosLanes), .words, .nWords);

	// ==========================================================
	// clock, comparators, watchdog
	initial forever #20 ref_clk = ~ref_clk;
	always_comb for (int i = 0; i < 8; i++)
		compKeep[i] = approxArray_q[20*i+:20] <= tgt[i];
	// words must not leave while samples are still held
	always @(posedge ref_clk) if (trackHold_q && wordStart_q) early++;
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		summarize;
	end

	// ==========================================================
	// tasks
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task summarize;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// kind 0 range, 1 offset, 2 gain, else auto gain mask
	task wr(input int k, input logic [2:0] ch, input logic [19:0] v);
		@(negedge ref_clk);
		case (k)
			0: {rangeWrEn, rangeWrChan, rangeWrCode} = {1'b1, ch, v[3:0]};
			1: {offsetWrEn, offsetWrChan, offsetWrValue} = {1'b1, ch, v};
			2: {gainWrEn, gainWrChan, gainWrValue} = {1'b1, ch, v[15:0]};
			default: {agrWrEn, agrWrMask} = {1'b1, v[7:0]};
		endcase
		@(negedge ref_clk);
		{rangeWrEn, offsetWrEn, gainWrEn, agrWrEn} = 4'h0;
	endtask
	task conv(input logic [7:0] sm);
		int n0, i;
		n0 = nWords;
		@(negedge ref_clk);
		conversionStart = 1;
		smallSignal = sm;
		@(posedge ref_clk);
		@(posedge ref_clk);
		#1 chk("hold", 1, trackHold_q);
		chk("busy", 1, busy_q);
		@(negedge ref_clk);
		conversionStart = 0;
		for (i = 0; i < 600 && nWords < n0 + 8; i++) @(posedge ref_clk);
		// return on a falling edge so that callers drive off the edge
		@(negedge ref_clk);
		chk("words", n0 + 8, nWords);
	endtask
	// sign extension for odd codes, zero fill for even ones, then
	// gain in units of 1/0x8000 and the signed offset
	function logic [23:0] fmt(input int i);
		logic signed [47:0] v;
		v = CODEW[4*i] ? $signed({{5{~tgt[i][19]}}, tgt[i][18:0]}) :
			$signed({4'h0, tgt[i]});
		v = (v * $signed({1'b0, gn[i]})) >>> 15;
		return 24'(v) + {{4{off[i][19]}}, off[i]};
	endfunction

	// ==========================================================
	// main sequence
	initial begin
		for (c = 0; c < 8; c++) begin
			tgt[c] = 20'(20'h1E1E3 * (c + 1));
			off[c] = 0;
			gn[c] = 16'h8000;
		end
		repeat (20) @(negedge ref_clk);
		rst_n = 1;
		@(negedge ref_clk);
		chk("ranges", 32'hFFFFFFFF, rangeCodes_q);
		chk("agr", 8'hFF, agrEn_q);
		for (c = 0; c < 8; c++) wr(0, c, CODEW[4*c+:4]);
		wr(3, 0, 8'hF0);
		wr(1, 3, 20'hFFFFE);
		off[3] = 20'hFFFFE;
		wr(2, 5, 16'h4000);
		gn[5] = 16'h4000;
		chk("ranges", CODEW, rangeCodes_q);
		chk("agr", 8'hF0, agrEn_q);
		conv(8'hFF);
		// span index is latched when the start edge is taken
		for (c = 0; c < 8; c++)
			chk("span", (15 - CODEW[4*c+:4]) >> 1, spanIdx_q[3*c+:3]);
		chk("gain", 8'hF0, gainSel_q);
		// high-gain samples come back scaled into the range format
		for (c = 4; c < 8; c++)
			chk("hiword", 24'($signed(fmt(c)) >>> 2), words[c]);
		wr(3, 0, 0);
		for (m = 0; m < 9; m++) begin
			lvdsSelect = m == 8;
			cmosLanes = m[2:0];
			conv(0);
			chk("oe", lvdsSelect ? 0 : (1 << (m + 1)) - 1, resultLinesOe_q);
			chk("lvdsoe", lvdsSelect, lvdsOe_q);
			for (c = 0; c < 8; c++) chk("word", fmt(c), words[c]);
		end
		// two-sample window: first start gives no words, busy stays
		osEnable = 1;
		c = nWords;
		conversionStart = 1;
		repeat (2) @(negedge ref_clk);
		conversionStart = 0;
		repeat (40) @(negedge ref_clk);
		chk("osbusy", 1, busy_q);
		chk("oswords", c, nWords);
		conv(0);
		// mean of two equal samples carries four fraction bits
		for (c = 0; c < 8; c++)
			chk("avg", 24'(fmt(c) << 4), words[c]);
		osEnable = 0;
		chk("early", 0, early);
		napReq = 1;
		repeat (3) @(negedge ref_clk);
		chk("pwr", PWR_NAP, powerState_q);
		conversionStart = 1;
		repeat (3) @(negedge ref_clk);
		chk("busy", 0, busy_q);
		{conversionStart, napReq, powerDownReq} = 3'h1;
		repeat (3) @(negedge ref_clk);
		chk("pwr", PWR_DOWN, powerState_q);
		powerDownReq = 0;
		repeat (3) @(negedge ref_clk);
		chk("pwr", PWR_ACTIVE, powerState_q);
		summarize;
	end
endmodule
